// File: hw/tc_fifo.sv
`timescale 1ns/1ps
module tc_fifo #(
	parameter int W = 15,
	parameter int DEPTH = 8
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_ce,
	// fill side
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [W-1:0] i_data,
	// drain side
	output logic o_valid,
	input wire logic i_ready,
	output logic [W-1:0] o_data
);
	localparam int PW = $clog2(DEPTH);
	logic [W-1:0] mem [0:DEPTH-1];
	logic [PW-1:0] wp_ff, rp_ff;
	logic [PW:0] cnt_ff;
	logic push, pop;
	if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_chk
		$error("tc_fifo: depth must be a power of two");
	end
	assign o_ready = cnt_ff != (PW+1)'(DEPTH);
	assign o_valid = cnt_ff != '0;
	assign o_data = mem[rp_ff];
	assign push = i_valid && o_ready;
	assign pop = o_valid && i_ready;
	always_ff @(posedge i_mclk) begin
		if (i_ce && push) mem[wp_ff] <= i_data;
	end
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			wp_ff <= '0;
			rp_ff <= '0;
			cnt_ff <= '0;
		end else if (i_ce) begin
			if (push) wp_ff <= wp_ff + 1'b1;
			if (pop) rp_ff <= rp_ff + 1'b1;
			cnt_ff <= cnt_ff + (PW+1)'(push) - (PW+1)'(pop);
		end
	end
endmodule // tc_fifo

// File: hw/tc_host_ctl.sv
// Overview of operation
// - host writes index to indirect index, then data access hits that register
// - index bit seven set makes every data access bump the stored index
// - status holds four event flags; reading it clears all four
// - serial receive flag clears on data read, transmit flag on data write
// - received code bits gather in a buffer, moved out after last data bit
// - each receive transfer sets the flag; interrupt only when its enable is one
// - receive registers stay unchanged until next frame's last data bit
// - lock bit set after valid sync while bits keep coming, else cleared
// - direction bit shows forward or reverse sync word orientation
// - while enabled, write registers copied to output buffer eight bits before end
// - each generated frame ends with sixteen sync bits after the data
// - transmit flag set each time write data move into the output buffer
// - on enable load buffer and flag, then start output on sync event
// - read line register: top bit enables, low five bits are line minus ten
// - field all ones scans from line ten or first line, stops on code or 41
// - no vertical code read without video genlock
// - vertical code bytes stored one at a time into read registers
// - crc result lands in bit five of the read line register
// - bit six set when a full vertical frame was not received
`timescale 1ns/1ps
module tc_host_ctl #(
	parameter int LOSS_CYCLES = tc_pkg::LOSS_CYCLES,
	parameter int FIFO_DEPTH = 8
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_ce,
	// host bus pins
	input wire logic i_cs_n,
	input wire logic i_ior_n,
	input wire logic i_iow_n,
	input wire logic [2:0] i_addr,
	input wire logic [7:0] i_data,
	output logic [7:0] o_data,
	output logic o_data_oe,
	output logic o_irq,
	// serial port core
	input wire logic i_ser_rx_evt,
	input wire logic i_ser_tx_evt,
	input wire logic [7:0] i_ser_rdata,
	output logic o_ser_rd,
	output logic o_ser_wr,
	output logic [7:0] o_ser_wdata,
	output logic [7:0] o_ser_cmd,
	output logic o_ser_irq,
	// longitudinal code pins and timing
	input wire logic i_ltc_bit,
	input wire logic i_ltc_clk,
	input wire logic i_gen_sync,
	input wire logic i_bit_tick,
	input wire logic i_timer_tick,
	output logic o_ltc_out,
	// video slicer
	input wire logic i_video_genlocked,
	input wire logic i_field_start,
	input wire logic i_line_start,
	input wire logic [5:0] i_line_num,
	input wire logic [7:0] i_vbyte,
	input wire logic i_vbyte_vld,
	input wire logic i_vframe_end,
	input wire logic i_vcrc_ok
);
	localparam logic [14:0] LOSS_N = 15'(LOSS_CYCLES);
	if (LOSS_CYCLES < 2 || LOSS_CYCLES > 32767 || FIFO_DEPTH < 8) begin : g_chk
		$error("tc_host_ctl: bad parameter");
	end

	function automatic logic [5:0] tgt_line(input logic [7:0] rl, input logic [5:0] scan);
		tgt_line = (rl[4:0] == tc_pkg::SCAN_CODE) ? scan : 6'(rl[4:0]) + tc_pkg::LINE_OFS;
	endfunction

	// pin synchronisers: {cs, ior, iow, addr, data, ltc bit, ltc clk, gen sync}
	logic [16:0] s1_ff, s2_ff, s3_ff;
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			s1_ff <= 17'h1C000;
			s2_ff <= 17'h1C000;
			s3_ff <= 17'h1C000;
		end else if (i_ce) begin
			s1_ff <= {i_cs_n, i_ior_n, i_iow_n, i_addr, i_data, i_ltc_bit, i_ltc_clk, i_gen_sync};
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end
	// a read starts at the ior fall; a write is taken at the iow rise, data from the stage before
	logic rd_go, wr_go, bit_go, gsync_go;
	logic [2:0] rd_a, wr_a;
	logic [7:0] wd;
	assign rd_go = !s2_ff[16] && !s2_ff[15] && s3_ff[15];
	assign wr_go = !s3_ff[16] && s2_ff[14] && !s3_ff[14];
	assign rd_a = s2_ff[13:11];
	assign wr_a = s3_ff[13:11];
	assign wd = s3_ff[10:3];
	assign bit_go = s2_ff[1] && !s3_ff[1];
	assign gsync_go = s2_ff[0] && !s3_ff[0];
	logic dat_rd, dat_wr, hwe;
	assign dat_rd = rd_go && rd_a == tc_pkg::A_DATA;
	assign dat_wr = wr_go && wr_a == tc_pkg::A_DATA;

	// indirect index
	logic [6:0] idx_ff;
	logic autoinc_ff;
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			idx_ff <= '0;
			autoinc_ff <= 1'b0;
		end else if (i_ce) begin
			if (wr_go && wr_a == tc_pkg::A_IDX) begin
				idx_ff <= wd[6:0];
				autoinc_ff <= wd[tc_pkg::AUTOINC_BIT];
			end else if ((dat_rd || dat_wr) && autoinc_ff) begin
				idx_ff <= idx_ff + 7'h01;
			end
		end
	end

	// indirect registers held in flops because the logic reads them, except vsrc_ff which nothing reads
	logic [63:0] wsh_ff;
	logic [7:0] rl1_ff, rl2_ff, vsrc_ff, virq_ff, gctl_ff;
	logic [1:0] vsel_ff;
	logic vend1, vend2;
	logic [3:0] vbcnt_ff;
	assign hwe = dat_wr;
	assign vend1 = i_vframe_end && vsel_ff == 2'h1;
	assign vend2 = i_vframe_end && vsel_ff == 2'h2;
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			wsh_ff <= '0;
			vsrc_ff <= tc_pkg::RST_BYTE;
			virq_ff <= tc_pkg::RST_BYTE;
			gctl_ff <= tc_pkg::RST_BYTE;
		end else if (i_ce && hwe) begin
			if (idx_ff[6:3] == tc_pkg::IX_LTC_WR[6:3]) wsh_ff[{idx_ff[2:0], 3'h0} +: 8] <= wd;
			if (idx_ff == tc_pkg::IX_VSRC) vsrc_ff <= wd;
			if (idx_ff == tc_pkg::IX_VIRQ) virq_ff <= wd;
			if (idx_ff == tc_pkg::IX_GCTL) gctl_ff <= wd;
		end
	end
	// host owns enable and line field, hardware owns the crc and no-code bits
	function automatic logic [7:0] rl_next(input logic [7:0] cur, input logic hw, input logic [7:0] w,
			input logic fe, input logic crc, input logic full);
		rl_next = cur;
		if (hw) rl_next = {w[7], cur[6:5], w[4:0]};
		if (fe) begin
			rl_next[tc_pkg::RL_CRC] = crc;
			rl_next[tc_pkg::RL_INCOMPLETE_FRAME_FLAG] = !full;
		end
	endfunction
	logic vfull;
	assign vfull = vbcnt_ff == tc_pkg::VITC_FRAME_BYTES;
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			rl1_ff <= tc_pkg::RST_BYTE;
			rl2_ff <= tc_pkg::RST_BYTE;
		end else if (i_ce) begin
			rl1_ff <= rl_next(rl1_ff, hwe && idx_ff == tc_pkg::IX_RL1, wd, vend1, i_vcrc_ok, vfull);
			rl2_ff <= rl_next(rl2_ff, hwe && idx_ff == tc_pkg::IX_RL2, wd, vend2, i_vcrc_ok, vfull);
		end
	end

	// event flags; a set in the clearing cycle wins
	logic [3:0] flg_ff;
	logic rx_en_ff, ser_rx_ff, ser_tx_ff, rx_done, tx_load, st_rd;
	logic [3:0] flg_set;
	assign st_rd = rd_go && rd_a == tc_pkg::A_IRQ;
	assign flg_set[tc_pkg::F_VL] = i_line_start && i_line_num == virq_ff[5:0];
	assign flg_set[tc_pkg::F_TM] = i_timer_tick;
	assign flg_set[tc_pkg::F_RX] = rx_done;
	assign flg_set[tc_pkg::F_TX] = tx_load;
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			flg_ff <= '0;
			rx_en_ff <= 1'b0;
			o_irq <= 1'b0;
		end else if (i_ce) begin
			flg_ff <= (st_rd ? 4'h0 : flg_ff) | flg_set;
			if (wr_go && wr_a == tc_pkg::A_IRQ) rx_en_ff <= wd[tc_pkg::RX_EN_BIT];
			o_irq <= flg_ff[tc_pkg::F_RX] && rx_en_ff;
		end
	end
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			ser_rx_ff <= 1'b0;
			ser_tx_ff <= 1'b0;
			o_ser_irq <= 1'b0;
			o_ser_rd <= 1'b0;
			o_ser_wr <= 1'b0;
			o_ser_wdata <= '0;
			o_ser_cmd <= '0;
		end else if (i_ce) begin
			ser_rx_ff <= i_ser_rx_evt || (ser_rx_ff && !(rd_go && rd_a == tc_pkg::A_SDATA));
			ser_tx_ff <= i_ser_tx_evt || (ser_tx_ff && !(wr_go && wr_a == tc_pkg::A_SDATA));
			o_ser_irq <= ser_rx_ff || ser_tx_ff;
			o_ser_rd <= rd_go && rd_a == tc_pkg::A_SDATA;
			o_ser_wr <= wr_go && wr_a == tc_pkg::A_SDATA;
			if (wr_go && wr_a == tc_pkg::A_SDATA) o_ser_wdata <= wd;
			if (wr_go && wr_a == tc_pkg::A_SCMD) o_ser_cmd <= wd;
		end
	end

	// longitudinal receiver
	logic [15:0] ssh_ff, nxt_ssh;
	logic [63:0] rtmp_ff;
	logic [6:0] rcnt_ff;
	logic [14:0] quiet_ff;
	logic locked_ff, dir_ff, xact_ff, lpush, fifo_rdy, vpush;
	logic [2:0] xbyte_ff;
	assign nxt_ssh = {ssh_ff[14:0], s2_ff[2]};
	assign lpush = xact_ff && fifo_rdy && !vpush;
	assign rx_done = lpush && xbyte_ff == 3'h7;
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			ssh_ff <= '0;
			rtmp_ff <= '0;
			rcnt_ff <= tc_pkg::LTC_FRAME_BITS;
			locked_ff <= 1'b0;
			dir_ff <= 1'b0;
			quiet_ff <= '0;
		end else if (i_ce) begin
			if (bit_go) begin
				ssh_ff <= nxt_ssh;
				quiet_ff <= '0;
				if (nxt_ssh == tc_pkg::SYNC_FWD || nxt_ssh == tc_pkg::SYNC_REV) begin
					locked_ff <= 1'b1;
					dir_ff <= nxt_ssh == tc_pkg::SYNC_REV;
					rcnt_ff <= '0;
				end else if (rcnt_ff < tc_pkg::LTC_DATA_BITS) begin
					rtmp_ff[rcnt_ff[5:0]] <= s2_ff[2];
					rcnt_ff <= rcnt_ff + 7'h01;
				end else if (rcnt_ff < tc_pkg::LTC_FRAME_BITS) begin
					rcnt_ff <= rcnt_ff + 7'h01;
				end else begin
					locked_ff <= 1'b0;
				end
			end else if (quiet_ff == LOSS_N - 15'h0001) begin
				locked_ff <= 1'b0;
			end else begin
				quiet_ff <= quiet_ff + 15'h0001;
			end
		end
	end
	// the copy out starts right after the last data bit, before the sync word
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			xact_ff <= 1'b0;
			xbyte_ff <= '0;
		end else if (i_ce) begin
			if (bit_go && rcnt_ff == tc_pkg::LTC_DATA_BITS - 7'h01 && !xact_ff) begin
				xact_ff <= 1'b1;
				xbyte_ff <= '0;
			end else if (lpush) begin
				xbyte_ff <= xbyte_ff + 3'h1;
				if (xbyte_ff == 3'h7) xact_ff <= 1'b0;
			end
		end
	end

	// longitudinal generator
	tc_pkg::gen_state_t gst_ff;
	logic [63:0] obuf_ff;
	logic [6:0] gcnt_ff;
	logic gen_en;
	assign gen_en = gctl_ff[tc_pkg::GEN_EN_BIT];
	assign tx_load = (gst_ff == tc_pkg::G_IDLE && gen_en) ||
		(gst_ff == tc_pkg::G_RUN && i_bit_tick && gcnt_ff == tc_pkg::LTC_FRAME_BITS - tc_pkg::LTC_EARLY);
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			gst_ff <= tc_pkg::G_IDLE;
			obuf_ff <= '0;
			gcnt_ff <= '0;
			o_ltc_out <= 1'b0;
		end else if (i_ce) begin
			if (tx_load) obuf_ff <= wsh_ff;
			case (gst_ff)
				tc_pkg::G_IDLE: begin
					if (gen_en) gst_ff <= tc_pkg::G_WAIT;
				end
				tc_pkg::G_WAIT: begin
					gcnt_ff <= '0;
					if (!gen_en) gst_ff <= tc_pkg::G_IDLE;
					else if (gsync_go) gst_ff <= tc_pkg::G_RUN;
				end
				tc_pkg::G_RUN: begin
					if (i_bit_tick) begin
						if (gcnt_ff < tc_pkg::LTC_DATA_BITS) o_ltc_out <= obuf_ff[gcnt_ff[5:0]];
						else o_ltc_out <= tc_pkg::SYNC_FWD[4'hF - gcnt_ff[3:0]];
						if (gcnt_ff == tc_pkg::LTC_FRAME_BITS - 7'h01) begin
							gcnt_ff <= '0;
							if (!gen_en) gst_ff <= tc_pkg::G_IDLE;
						end else begin
							gcnt_ff <= gcnt_ff + 7'h01;
						end
					end
				end
				default: gst_ff <= tc_pkg::G_IDLE;
			endcase
		end
	end

	// vertical interval reader
	logic [5:0] scan1_ff, scan2_ff, t1, t2;
	logic act1, act2;
	assign t1 = tgt_line(rl1_ff, scan1_ff);
	assign t2 = tgt_line(rl2_ff, scan2_ff);
	assign act1 = rl1_ff[tc_pkg::RL_EN] && i_line_num == t1;
	assign act2 = rl2_ff[tc_pkg::RL_EN] && i_line_num == t2 && !act1;
	assign vpush = i_vbyte_vld && vsel_ff != 2'h0 && vbcnt_ff < tc_pkg::VITC_FRAME_BYTES - 4'h1;
	function automatic logic [5:0] scan_next(input logic [5:0] cur, input logic fe);
		scan_next = (fe && cur < tc_pkg::SCAN_LAST) ? cur + 6'h01 : cur;
	endfunction
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			vsel_ff <= '0;
			vbcnt_ff <= '0;
			scan1_ff <= tc_pkg::LINE_OFS;
			scan2_ff <= tc_pkg::LINE_OFS;
		end else if (i_ce) begin
			if (i_field_start) begin
				scan1_ff <= tc_pkg::LINE_OFS;
				scan2_ff <= tgt_line(rl1_ff, tc_pkg::LINE_OFS);
			end else begin
				scan1_ff <= scan_next(scan1_ff, vend1 && !(i_vcrc_ok && vfull));
				scan2_ff <= scan_next(scan2_ff, vend2 && !(i_vcrc_ok && vfull));
			end
			if (i_line_start) begin
				vsel_ff <= !i_video_genlocked ? 2'h0 : act1 ? 2'h1 : act2 ? 2'h2 : 2'h0;
				vbcnt_ff <= '0;
			end else if (i_vbyte_vld && vsel_ff != 2'h0 && !vfull) begin
				vbcnt_ff <= vbcnt_ff + 4'h1;
			end
		end
	end

	// byte path into the register memory; the drain stalls behind host writes
	logic [14:0] fin, fout;
	logic fvld;
	assign fin = vpush ? {(vsel_ff == 2'h1 ? tc_pkg::IX_VRD1 : tc_pkg::IX_VRD2) + 7'(vbcnt_ff), i_vbyte} :
		{tc_pkg::IX_LTC_RD + 7'(xbyte_ff), rtmp_ff[{xbyte_ff, 3'h0} +: 8]};
	tc_fifo #(.W(15), .DEPTH(FIFO_DEPTH)) i_tc_fifo (
		.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce),
		.i_valid(vpush || xact_ff), .o_ready(fifo_rdy), .i_data(fin),
		.o_valid(fvld), .i_ready(!hwe), .o_data(fout)
	);
	logic [7:0] mrd;
	tc_regmem #(.AW(7), .DW(8)) i_tc_regmem (
		.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce),
		.i_hwe(hwe), .i_haddr(idx_ff), .i_hdata(wd),
		.i_lwe(fvld && !hwe), .i_laddr(fout[14:8]), .i_ldata(fout[7:0]),
		.o_rdata(mrd)
	);

	// host read data: direct registers answer at once, indirect ones one cycle later
	logic ipend_ff;
	logic [2:0] isel_ff;
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_data <= '0;
			o_data_oe <= 1'b0;
			ipend_ff <= 1'b0;
			isel_ff <= '0;
		end else if (i_ce) begin
			o_data_oe <= !s2_ff[16] && !s2_ff[15];
			ipend_ff <= dat_rd;
			isel_ff <= idx_ff == tc_pkg::IX_RL1 ? 3'h1 : idx_ff == tc_pkg::IX_RL2 ? 3'h2 :
				idx_ff == tc_pkg::IX_GCTL ? 3'h3 : 3'h0;
			if (ipend_ff) begin
				case (isel_ff)
					3'h1: o_data <= rl1_ff;
					3'h2: o_data <= rl2_ff;
					3'h3: o_data <= gctl_ff;
					default: o_data <= mrd;
				endcase
			end else if (rd_go) begin
				case (rd_a)
					tc_pkg::A_IRQ: o_data <= {rx_en_ff, 3'h0, flg_ff};
					tc_pkg::A_LOCK: o_data <= {5'h00, i_video_genlocked, dir_ff, locked_ff};
					tc_pkg::A_IDX: o_data <= {autoinc_ff, idx_ff};
					tc_pkg::A_SCMD: o_data <= {ser_rx_ff || ser_tx_ff, 5'h00, ser_tx_ff, ser_rx_ff};
					tc_pkg::A_SDATA: o_data <= i_ser_rdata;
					default: o_data <= 8'h00;
				endcase
			end
		end
	end

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst || !i_ce);
	sequence s_ind_access;
		(dat_rd || dat_wr) && autoinc_ff && !(wr_go && wr_a == tc_pkg::A_IDX);
	endsequence
	property p_autoinc;
		logic [6:0] v;
		(s_ind_access, v = idx_ff) |=> idx_ff == v + 7'h01;
	endproperty
	a_autoinc: assert property (p_autoinc) else $error("index did not advance");
	property p_stat_clear;
		st_rd && flg_set == 4'h0 |=> flg_ff == 4'h0;
	endproperty
	a_stat_clear: assert property (p_stat_clear) else $error("status not cleared");
	property p_ser_rx;
		rd_go && rd_a == tc_pkg::A_SDATA && !i_ser_rx_evt |=> !ser_rx_ff;
	endproperty
	a_ser_rx: assert property (p_ser_rx) else $error("serial rx flag kept");
	property p_rx_irq;
		rx_done && rx_en_ff |=> ##1 o_irq;
	endproperty
	a_rx_irq: assert property (p_rx_irq) else $error("rx interrupt missing");
	property p_hold;
		$rose(xact_ff) |-> $past(bit_go) && $past(rcnt_ff) == tc_pkg::LTC_DATA_BITS - 7'h01;
	endproperty
	a_hold: assert property (p_hold) else $error("transfer not at last data bit");
	sequence s_wait;
		gst_ff == tc_pkg::G_WAIT && !gsync_go;
	endsequence
	property p_wait_sync;
		s_wait |=> gst_ff != tc_pkg::G_RUN;
	endproperty
	a_wait_sync: assert property (p_wait_sync) else $error("started without sync");
	property p_early_copy;
		gst_ff == tc_pkg::G_RUN && i_bit_tick && gcnt_ff == 7'h48 |=> flg_ff[tc_pkg::F_TX] && obuf_ff == $past(wsh_ff);
	endproperty
	a_early_copy: assert property (p_early_copy) else $error("late buffer copy");
	property p_sync_tail;
		gst_ff == tc_pkg::G_RUN && i_bit_tick && gcnt_ff == 7'h4F |=> o_ltc_out == 1'b1;
	endproperty
	a_sync_tail: assert property (p_sync_tail) else $error("bad sync tail");
	property p_nolock;
		i_line_start && !i_video_genlocked |=> vsel_ff == 2'h0 && !vpush;
	endproperty
	a_nolock: assert property (p_nolock) else $error("read without genlock");
	property p_incomplete_frame_flag;
		vend1 && !vfull |=> rl1_ff[tc_pkg::RL_INCOMPLETE_FRAME_FLAG];
	endproperty
	a_incomplete_frame_flag: assert property (p_incomplete_frame_flag) else $error("no-code bit not set");
endmodule // tc_host_ctl

// File: hw/tc_regmem.sv
`timescale 1ns/1ps
module tc_regmem #(
	parameter int AW = 7,
	parameter int DW = 8
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_ce,
	// host write and read port
	input wire logic i_hwe,
	input wire logic [AW-1:0] i_haddr,
	input wire logic [DW-1:0] i_hdata,
	// hardware write port
	input wire logic i_lwe,
	input wire logic [AW-1:0] i_laddr,
	input wire logic [DW-1:0] i_ldata,
	output logic [DW-1:0] o_rdata
);
	logic [DW-1:0] mem [0:(1<<AW)-1];
	if (AW < 6 || DW < 1) begin : g_chk
		$error("tc_regmem: bad size");
	end
	// hardware writes land after host writes so a same-address clash keeps fresh status
	always_ff @(posedge i_mclk) begin
		if (i_ce && i_hwe) mem[i_haddr] <= i_hdata;
		if (i_ce && i_lwe) mem[i_laddr] <= i_ldata;
	end
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) o_rdata <= '0;
		else if (i_ce) o_rdata <= mem[i_haddr];
	end
endmodule // tc_regmem

// File: shared/tc_pkg.sv
package tc_pkg;
	// direct host addresses
	localparam logic [2:0] A_IRQ = 3'h0;
	localparam logic [2:0] A_LOCK = 3'h1;
	localparam logic [2:0] A_IDX = 3'h2;
	localparam logic [2:0] A_DATA = 3'h3;
	localparam logic [2:0] A_SCMD = 3'h4;
	localparam logic [2:0] A_SDATA = 3'h5;
	// indirect indices
	localparam logic [6:0] IX_LTC_RD = 7'h00;
	localparam logic [6:0] IX_LTC_WR = 7'h08;
	localparam logic [6:0] IX_VRD1 = 7'h10;
	localparam logic [6:0] IX_VRD2 = 7'h18;
	localparam logic [6:0] IX_RL1 = 7'h30;
	localparam logic [6:0] IX_RL2 = 7'h31;
	localparam logic [6:0] IX_VSRC = 7'h32;
	localparam logic [6:0] IX_VIRQ = 7'h33;
	localparam logic [6:0] IX_GCTL = 7'h34;
	// field positions
	localparam int AUTOINC_BIT = 7;
	localparam int F_RX = 0;
	localparam int F_TX = 1;
	localparam int F_VL = 2;
	localparam int F_TM = 3;
	localparam int RX_EN_BIT = 7;
	localparam int RL_EN = 7;
	localparam int RL_INCOMPLETE_FRAME_FLAG = 6;
	localparam int RL_CRC = 5;
	localparam int GEN_EN_BIT = 0;
	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	// code framing
	localparam logic [5:0] LINE_OFS = 6'h0A;
	localparam logic [4:0] SCAN_CODE = 5'h1F;
	localparam logic [5:0] SCAN_LAST = 6'h29;
	localparam logic [6:0] LTC_DATA_BITS = 7'h40;
	localparam logic [6:0] LTC_FRAME_BITS = 7'h50;
	localparam logic [6:0] LTC_EARLY = 7'h08;
	localparam logic [15:0] SYNC_FWD = 16'h3FFD;
	localparam logic [15:0] SYNC_REV = 16'hBFFC;
	localparam logic [3:0] VITC_FRAME_BYTES = 4'h9;
	// timing
	localparam int CLK_MHZ = 20;
	localparam int LOSS_TIME_US = 1000;
	localparam int LOSS_CYCLES = LOSS_TIME_US * CLK_MHZ;
	typedef enum logic [1:0] {
		G_IDLE = 2'b00,
		G_WAIT = 2'b01,
		G_RUN = 2'b10
	} gen_state_t;
endpackage

// File: verif/host_bus_model.sv
`timescale 1ns/1ps
module host_bus_model (
	// bus pins toward the device
	input wire logic i_mclk,
	input wire logic [7:0] i_data,
	output logic o_cs_n,
	output logic o_ior_n,
	output logic o_iow_n,
	output logic [2:0] o_addr,
	output logic [7:0] o_data
);
	initial begin
		o_cs_n = 1'b1;
		o_ior_n = 1'b1;
		o_iow_n = 1'b1;
		o_addr = 3'h7;
		o_data = 8'hA5;
	end
	// one access; index then data is the caller's order
	task automatic cyc(input logic [2:0] a, input logic wr, input logic [7:0] d, output logic [7:0] q);
		@(posedge i_mclk);
		o_cs_n <= 1'b0;
		o_addr <= a;
		o_data <= d;
		o_ior_n <= wr;
		o_iow_n <= !wr;
		// long strobe covers the synchronizer and the indirect answer
		repeat (8) @(posedge i_mclk);
		q = i_data;
		o_ior_n <= 1'b1;
		o_iow_n <= 1'b1;
		// cs, address and data outlive the strobe since the write uses a late sample
		repeat (4) @(posedge i_mclk);
		o_cs_n <= 1'b1;
		o_addr <= ~a;
		o_data <= ~d;
		repeat (4) @(posedge i_mclk);
	endtask
endmodule // host_bus_model

// File: verif/test_tc_host_ctl.sv
`timescale 1ns/1ps
module test_tc_host_ctl;
	logic i_mclk = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_cs_n, i_ior_n, i_iow_n;
	logic [2:0] i_addr;
	logic [7:0] i_data, o_data, o_ser_wdata, o_ser_cmd, q;
	logic o_data_oe, o_irq, o_ser_rd, o_ser_wr, o_ser_irq, o_ltc_out;
	logic i_ser_rx_evt = 0, i_ser_tx_evt = 0, i_ltc_bit = 0, i_ltc_clk = 0, i_gen_sync = 0, i_bit_tick = 0;
	logic i_timer_tick = 0, i_video_genlocked = 0, i_field_start = 0, i_line_start = 0;
	logic i_vbyte_vld = 0, i_vframe_end = 0, i_vcrc_ok = 0;
	logic [7:0] i_ser_rdata = 8'h5C, i_vbyte = 8'h00;
	logic [5:0] i_line_num = 6'h00;
	int num_errors = 0;
	int n_checks = 0;
	int ser_pulses = 0, oe_cycles = 0;
	// one-cycle strobes and the bus enable are counted so they can be judged after the access
	always @(posedge i_mclk) begin
		ser_pulses <= ser_pulses + int'(o_ser_rd) + int'(o_ser_wr);
		oe_cycles <= oe_cycles + int'(o_data_oe);
	end
	tc_host_ctl #(.LOSS_CYCLES(50)) i_tc_host_ctl (.*);
	host_bus_model i_host_bus_model (.i_mclk(i_mclk), .i_data(o_data), .o_cs_n(i_cs_n), .o_ior_n(i_ior_n),
		.o_iow_n(i_iow_n), .o_addr(i_addr), .o_data(i_data));
	initial forever #25 i_mclk = ~i_mclk;
	function automatic logic [7:0] pat(int n);
		return 8'h3C ^ 8'(n * 37);
	endfunction
	task automatic give_verdict();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		i_host_bus_model.cyc(a, 1'b1, d, q);
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
		i_host_bus_model.cyc(a, 1'b0, 8'h00, q);
		chk(q & m, e);
	endtask
	task automatic send_bit(input logic b);
		@(posedge i_mclk) i_ltc_bit <= b;
		repeat (3) @(posedge i_mclk);
		i_ltc_clk <= 1'b1;
		repeat (3) @(posedge i_mclk);
		i_ltc_clk <= 1'b0;
	endtask
	task automatic t_index();
		wr(tc_pkg::A_IDX, 8'hFE);
		for (int k = 0; k < 4; k++) wr(tc_pkg::A_DATA, 8'hA1 + 8'(k));
		wr(tc_pkg::A_IDX, 8'hFE);
		for (int k = 0; k < 4; k++) rd(tc_pkg::A_DATA, 8'hA1 + 8'(k));
		wr(tc_pkg::A_IDX, 8'h7F);
		rd(tc_pkg::A_DATA, 8'hA2);
		rd(tc_pkg::A_DATA, 8'hA2);
		rd(3'h6, 8'h00);
		$display("index test done");
	endtask
	task automatic t_flags();
		int oe0;
		@(posedge i_mclk) i_timer_tick <= 1'b1;
		@(posedge i_mclk) i_timer_tick <= 1'b0;
		oe0 = oe_cycles;
		rd(tc_pkg::A_IRQ, 8'h08);
		chk(8'(oe_cycles - oe0), 8'h08);
		rd(tc_pkg::A_IRQ, 8'h00);
		@(posedge i_mclk) i_ser_rx_evt <= 1'b1;
		@(posedge i_mclk) i_ser_rx_evt <= 1'b0;
		rd(tc_pkg::A_SCMD, 8'h01, 8'h01);
		chk({7'h00, o_ser_irq}, 8'h01);
		rd(tc_pkg::A_SDATA, 8'h5C);
		chk(8'(ser_pulses), 8'h01);
		rd(tc_pkg::A_SCMD, 8'h00, 8'h01);
		chk({7'h00, o_ser_irq}, 8'h00);
		@(posedge i_mclk) i_ser_tx_evt <= 1'b1;
		@(posedge i_mclk) i_ser_tx_evt <= 1'b0;
		rd(tc_pkg::A_SCMD, 8'h02, 8'h02);
		wr(tc_pkg::A_SDATA, 8'hC3);
		chk(o_ser_wdata, 8'hC3);
		chk(8'(ser_pulses), 8'h02);
		rd(tc_pkg::A_SCMD, 8'h00, 8'h02);
		wr(tc_pkg::A_SCMD, 8'h5A);
		chk(o_ser_cmd, 8'h5A);
		$display("flag test done");
	endtask
	task automatic t_rx();
		wr(tc_pkg::A_IRQ, 8'h80);
		for (int k = 15; k >= 0; k--) send_bit(tc_pkg::SYNC_FWD[k]);
		for (int k = 0; k < 64; k++) begin
			q = pat(k / 8);
			send_bit(q[k % 8]);
		end
		rd(tc_pkg::A_LOCK, 8'h01, 8'h03);
		chk({7'h00, o_irq}, 8'h01);
		rd(tc_pkg::A_IRQ, 8'h81);
		chk({7'h00, o_irq}, 8'h00);
		wr(tc_pkg::A_IDX, 8'h80);
		for (int n = 0; n < 8; n++) rd(tc_pkg::A_DATA, pat(n));
		rd(tc_pkg::A_LOCK, 8'h00, 8'h01);
		// a new sync and part of a frame must not disturb the stored frame
		for (int k = 0; k < 46; k++) send_bit(k < 16 ? tc_pkg::SYNC_FWD[15 - k] : k[0]);
		wr(tc_pkg::A_IDX, 8'h00);
		rd(tc_pkg::A_DATA, pat(0));
		$display("receive test done");
	endtask
	task automatic vline(input logic [5:0] ln, input int nb, input logic ok);
		@(posedge i_mclk) begin
			i_line_num <= ln;
			i_line_start <= 1'b1;
		end
		@(posedge i_mclk) i_line_start <= 1'b0;
		for (int n = 0; n < nb; n++) begin
			@(posedge i_mclk) begin
				i_vbyte <= pat(n + 8);
				i_vbyte_vld <= 1'b1;
			end
			@(posedge i_mclk) i_vbyte_vld <= 1'b0;
		end
		@(posedge i_mclk) begin
			i_vcrc_ok <= ok;
			i_vframe_end <= 1'b1;
		end
		@(posedge i_mclk) i_vframe_end <= 1'b0;
	endtask
	task automatic t_vitc();
		wr(tc_pkg::A_IDX, 8'hB2);
		wr(tc_pkg::A_DATA, 8'h01); // genlock on, timing reset off
		wr(tc_pkg::A_DATA, 8'h14); // line 20, after every read line
		wr(tc_pkg::A_IDX, 8'h30);
		wr(tc_pkg::A_DATA, 8'h85);
		vline(6'h0F, 9, 1'b1);
		rd(tc_pkg::A_DATA, 8'h85);
		i_video_genlocked <= 1'b1;
		vline(6'h0F, 9, 1'b1);
		rd(tc_pkg::A_DATA, 8'hA5);
		vline(6'h0F, 5, 1'b0);
		rd(tc_pkg::A_DATA, 8'hC5);
		vline(6'h14, 0, 1'b0);
		rd(tc_pkg::A_IRQ, 8'h04, 8'h04);
		wr(tc_pkg::A_IDX, 8'h90);
		for (int n = 0; n < 8; n++) rd(tc_pkg::A_DATA, pat(n + 8));
		wr(tc_pkg::A_IDX, 8'h30);
		wr(tc_pkg::A_DATA, 8'h9F);
		@(posedge i_mclk) i_field_start <= 1'b1;
		@(posedge i_mclk) i_field_start <= 1'b0;
		vline(6'h0A, 5, 1'b0);
		vline(6'h0B, 9, 1'b1);
		rd(tc_pkg::A_DATA, 8'hBF);
		$display("vertical test done");
	endtask
	task automatic t_gen();
		wr(tc_pkg::A_IRQ, 8'h00);
		wr(tc_pkg::A_IDX, 8'h88);
		for (int n = 0; n < 8; n++) wr(tc_pkg::A_DATA, ~pat(n));
		wr(tc_pkg::A_IDX, 8'h34);
		wr(tc_pkg::A_DATA, 8'h01);
		rd(tc_pkg::A_IRQ, 8'h02, 8'h02);
		@(posedge i_mclk) i_gen_sync <= 1'b1;
		repeat (6) @(posedge i_mclk);
		for (int k = 0; k < 80; k++) begin
			q = ~pat(k / 8);
			@(posedge i_mclk) i_bit_tick <= 1'b1;
			@(posedge i_mclk) i_bit_tick <= 1'b0;
			repeat (2) @(posedge i_mclk);
			chk({7'h00, o_ltc_out}, {7'h00, k < 64 ? q[k % 8] : tc_pkg::SYNC_FWD[79 - k]});
		end
		rd(tc_pkg::A_IRQ, 8'h02, 8'h02);
		$display("generator test done");
	endtask
	initial begin
		repeat (4) @(posedge i_mclk);
		i_rst <= 1'b0;
		repeat (3) @(posedge i_mclk);
		t_index();
		t_flags();
		t_rx();
		t_vitc();
		t_gen();
		give_verdict();
	end
endmodule // test_tc_host_ctl
